// [core_special_registers.v]
// core special registers: program counter, return stack, status, pointer, ports, nvm regs
`timescale 1ns/1ps
`default_nettype none
`include "core_special_registers_defs.vh"

// Operation
// - pc and stack entries thirteen bits wide
// - eight-entry stack, push on call or interrupt
// - pop stack into pc on any return
// - jump, call, low write take latch high bits
// - carry flag set on carry out bit 7
// - rotates shift through the carry flag
// - nibble flag set on carry out bit 3
// - zero flag set on zero result
// - sleep flag set by power-up, kick; cleared halting
// - watchdog flag set power-up/kick/halt; cleared timeout
// - reset flag values follow the sleep state; external reset while awake keeps the flags
// - bank bits select 128-byte bank, high stores
// - indirect bank bit is plain storage
// - address 00h accesses register the pointer selects
// - port A five bits, reads return pins
// - port A bit 4 open collector only
// - port B weak pull-ups, off for outputs
// - pull-ups disabled after power-on reset
// - port B 4-7 input changes raise flag
// - port B change wakes device from halt
// - nvm data and address registers, 64 locations
// - option bit 7 disables all pull-ups
// - port B change flag sticky until cleared
// - port A direction 1 input, 0 output
module core_special_registers (
    // clock, reset, enable
    input wire ref_clk_i,
    input wire reset_n_i,
    input wire clk_en_i,
    // register port
    input wire [6:0] reg_addr_i,
    input wire [7:0] reg_wdata_i,
    input wire reg_wr_i,
    input wire reg_rd_i,
    output reg [7:0] reg_rdata_o,
    // sequencer controls
    input wire pc_step_i,
    input wire jump_i,
    input wire call_i,
    input wire [7:0] target_i,
    input wire int_ack_i,
    input wire return_i,
    input wire halt_i,
    input wire wdt_kick_i,
    input wire wdt_timeout_i,
    input wire ext_reset_i,
    output wire [12:0] pc_o,
    output wire asleep_o,
    // alu flag sources
    input wire arith_valid_i,
    input wire arith_sub_i,
    input wire [7:0] op_a_i,
    input wire [7:0] op_b_i,
    input wire logic_valid_i,
    input wire [7:0] logic_result_i,
    input wire rotate_left_i,
    input wire rotate_right_i,
    input wire [7:0] rotate_src_i,
    // nvm side
    input wire nvm_load_i,
    input wire [7:0] nvm_rdata_i,
    output wire [5:0] nvm_addr_o,
    output wire [7:0] nvm_data_o,
    // port pins
    input wire [4:0] port_a_pin_i,
    output wire [4:0] port_a_out_o,
    output wire [4:0] port_a_oe_o,
    input wire [7:0] port_b_pin_i,
    output wire [7:0] port_b_out_o,
    output wire [7:0] port_b_oe_o,
    output wire [7:0] port_b_pullup_en_o,
    output wire port_change_flag_o
);

// =============================================
// state
reg [12:0] pc_reg;
reg [12:0] stack_mem [0:7];
reg [2:0] sp_reg;
reg [7:0] status_reg;
reg [7:0] pointer_reg;
reg [4:0] pc_latch_reg;
reg [7:0] option_reg;
reg [7:0] int_ctrl_reg;
reg [4:0] pa_latch_reg;
reg [4:0] pa_dir_reg;
reg [7:0] pb_latch_reg;
reg [7:0] pb_dir_reg;
reg [7:0] nvm_data_reg;
reg [7:0] nvm_addr_reg;
reg asleep_reg;
reg [4:0] pa_sync1_reg;
reg [4:0] pa_sync2_reg;
reg [7:0] pb_sync1_reg;
reg [7:0] pb_sync2_reg;
reg [3:0] pb_prev_reg;
reg [`PB_FILL_MSB:0] pb_fill_reg;

// =============================================
// address resolution
wire [7:0] direct_addr;
wire [7:0] eff_addr;
wire [8:0] arith_sum;
wire [4:0] nibble_sum;
wire [7:0] b_operand;
wire [7:0] arith_result;
wire [3:0] pb_change;
wire pb_change_any;
wire [2:0] sp_pop;
wire [12:0] pc_latched_target;
wire wdt_reset;

// bank bit low picks the bank, high bank bit never reaches the decode
assign direct_addr = {status_reg[`ST_BANK_LO], reg_addr_i};
assign eff_addr = (direct_addr & `ADDR_DIRECT_MASK) == `ADDR_INDIRECT ?
    pointer_reg : direct_addr;

// =============================================
// alu flags
// subtraction adds the two's complement, so carry means no borrow
// the +1 rides in as carry-in, so subtracting zero still carries out of both bits
assign b_operand = arith_sub_i ? ~op_b_i : op_b_i;
assign arith_sum = {1'b0, op_a_i} + {1'b0, b_operand} + {`BYTE_ZERO, arith_sub_i};
assign nibble_sum = {1'b0, op_a_i[`NIBBLE_MSB:0]} + {1'b0, b_operand[`NIBBLE_MSB:0]}
    + {4'h0, arith_sub_i};
assign arith_result = arith_sum[7:0];

// =============================================
// port B change detection, outputs excluded
// gated until the reference holds a real pin level, else an idle-high pin fakes an edge
assign pb_change = (pb_sync2_reg[7:4] ^ pb_prev_reg) & pb_dir_reg[7:4]
    & {4{pb_fill_reg[`PB_FILL_MSB]}};
assign pb_change_any = |pb_change;

// a watchdog time-out is a reset of the core, whether it runs or sleeps
assign wdt_reset = wdt_timeout_i;
assign sp_pop = sp_reg - `SP_ONE;
assign pc_latched_target = {pc_latch_reg, target_i};

// =============================================
// program counter and stack
always @(posedge ref_clk_i or negedge reset_n_i)
begin
    if (!reset_n_i)
    begin
        pc_reg <= `RESET_VECTOR;
        sp_reg <= 3'h0;
    end
    else if (clk_en_i)
    begin
        if (ext_reset_i || wdt_reset)
        begin
            pc_reg <= `RESET_VECTOR;
            sp_reg <= 3'h0;
        end
        else if (int_ack_i)
        begin
            stack_mem[sp_reg] <= pc_reg;
            sp_reg <= sp_reg + `SP_ONE;
            pc_reg <= `INT_VECTOR;
        end
        else if (call_i)
        begin
            stack_mem[sp_reg] <= pc_reg + `PC_ONE;
            sp_reg <= sp_reg + `SP_ONE;
            pc_reg <= pc_latched_target;
        end
        else if (jump_i)
            pc_reg <= pc_latched_target;
        else if (return_i)
        begin
            pc_reg <= stack_mem[sp_pop];
            sp_reg <= sp_pop;
        end
        else if (reg_wr_i && eff_addr[6:0] == `ADDR_PC_LOW)
            pc_reg <= {pc_latch_reg, reg_wdata_i};
        else if (pc_step_i && !asleep_reg)
            pc_reg <= pc_reg + `PC_ONE;
    end
end

// =============================================
// status register and sleep state
always @(posedge ref_clk_i or negedge reset_n_i)
begin
    if (!reset_n_i)
    begin
        status_reg <= `STATUS_RESET; // power-up: sleep and watchdog flags set
        asleep_reg <= 1'b0;
    end
    else if (clk_en_i)
    begin
        if (wdt_reset)
        begin
            status_reg[`ST_SLEEP] <= ~asleep_reg;
            status_reg[`ST_WDOG] <= 1'b0;
            status_reg[`ST_IND_BANK:`ST_BANK_LO] <= 3'h0;
            asleep_reg <= 1'b0;
        end
        else if (ext_reset_i)
        begin
            // awake: flags keep their previous values
            if (asleep_reg)
            begin
                status_reg[`ST_SLEEP] <= 1'b0;
                status_reg[`ST_WDOG] <= 1'b1;
            end
            status_reg[`ST_IND_BANK:`ST_BANK_LO] <= 3'h0;
            asleep_reg <= 1'b0;
        end
        else
        begin
            if (reg_wr_i && eff_addr[6:0] == `ADDR_STATUS)
            begin
                // sleep and watchdog flags are read-only to software
                status_reg[`ST_IND_BANK:`ST_BANK_LO] <= reg_wdata_i[7:5];
                status_reg[`ST_ZERO:`ST_CARRY] <= reg_wdata_i[2:0];
            end
            if (arith_valid_i)
            begin
                status_reg[`ST_CARRY] <= arith_sum[8];
                status_reg[`ST_NIBBLE] <= nibble_sum[4];
                status_reg[`ST_ZERO] <= arith_result == `BYTE_ZERO;
            end
            else if (logic_valid_i)
                status_reg[`ST_ZERO] <= logic_result_i == `BYTE_ZERO;
            if (rotate_left_i)
                status_reg[`ST_CARRY] <= rotate_src_i[`ALU_MSB];
            else if (rotate_right_i)
                status_reg[`ST_CARRY] <= rotate_src_i[`ALU_LSB];
            if (wdt_kick_i)
            begin
                status_reg[`ST_SLEEP] <= 1'b1;
                status_reg[`ST_WDOG] <= 1'b1;
            end
            else if (halt_i)
            begin
                status_reg[`ST_SLEEP] <= 1'b0;
                status_reg[`ST_WDOG] <= 1'b1;
                asleep_reg <= 1'b1;
            end
            if (asleep_reg && pb_change_any)
                asleep_reg <= 1'b0;
        end
    end
end

// =============================================
// software registers and port change flag
always @(posedge ref_clk_i or negedge reset_n_i)
begin
    if (!reset_n_i)
    begin
        pointer_reg <= `BYTE_ZERO;
        pc_latch_reg <= 5'h00;
        option_reg <= `OPTION_RESET;
        int_ctrl_reg <= `BYTE_ZERO;
        pa_latch_reg <= 5'h00;
        pa_dir_reg <= `DIR_A_RESET;
        pb_latch_reg <= `BYTE_ZERO;
        pb_dir_reg <= `DIR_B_RESET;
        nvm_data_reg <= `BYTE_ZERO;
        nvm_addr_reg <= `BYTE_ZERO;
    end
    else if (clk_en_i)
    begin
        if (reg_wr_i)
        begin
            case (eff_addr)
                `ADDR_POINTER, `ADDR_POINTER | 8'h80: pointer_reg <= reg_wdata_i;
                `ADDR_PC_LATCH, `ADDR_PC_LATCH | 8'h80: pc_latch_reg <= reg_wdata_i[4:0];
                `ADDR_INT_CTRL, `ADDR_INT_CTRL | 8'h80: int_ctrl_reg <= reg_wdata_i;
                `ADDR_OPTION: option_reg <= reg_wdata_i;
                `ADDR_PORT_A: pa_latch_reg <= reg_wdata_i[4:0];
                `ADDR_PORT_A_DIR: pa_dir_reg <= reg_wdata_i[4:0];
                `ADDR_PORT_B: pb_latch_reg <= reg_wdata_i;
                `ADDR_PORT_B_DIR: pb_dir_reg <= reg_wdata_i;
                `ADDR_NVM_DATA: nvm_data_reg <= reg_wdata_i;
                `ADDR_NVM_ADDR: nvm_addr_reg <= reg_wdata_i;
                default: ;
            endcase
        end
        if (nvm_load_i)
            nvm_data_reg <= nvm_rdata_i;
        // a change in the same cycle as a software clear still lands
        if (pb_change_any)
            int_ctrl_reg[`INT_PB_CHANGE] <= 1'b1;
    end
end

// =============================================
// pin synchronisers and change reference
always @(posedge ref_clk_i or negedge reset_n_i)
begin
    if (!reset_n_i)
    begin
        pa_sync1_reg <= 5'h00;
        pa_sync2_reg <= 5'h00;
        pb_sync1_reg <= `BYTE_ZERO;
        pb_sync2_reg <= `BYTE_ZERO;
        pb_prev_reg <= 4'h0;
        pb_fill_reg <= 3'h0;
    end
    else if (clk_en_i)
    begin
        pa_sync1_reg <= port_a_pin_i;
        pa_sync2_reg <= pa_sync1_reg;
        pb_sync1_reg <= port_b_pin_i;
        pb_sync2_reg <= pb_sync1_reg;
        pb_prev_reg <= pb_sync2_reg[7:4];
        pb_fill_reg <= {pb_fill_reg[`PB_FILL_MSB - 1:0], 1'b1};
    end
end

// =============================================
// read port, data one cycle after the strobe
always @(posedge ref_clk_i or negedge reset_n_i)
begin
    if (!reset_n_i)
        reg_rdata_o <= `BYTE_ZERO;
    else if (clk_en_i && reg_rd_i)
    begin
        case (eff_addr)
            `ADDR_PC_LOW, `ADDR_PC_LOW | 8'h80: reg_rdata_o <= pc_reg[7:0];
            `ADDR_STATUS, `ADDR_STATUS | 8'h80: reg_rdata_o <= status_reg;
            `ADDR_POINTER, `ADDR_POINTER | 8'h80: reg_rdata_o <= pointer_reg;
            `ADDR_PC_LATCH, `ADDR_PC_LATCH | 8'h80: reg_rdata_o <= {3'h0, pc_latch_reg};
            `ADDR_INT_CTRL, `ADDR_INT_CTRL | 8'h80: reg_rdata_o <= int_ctrl_reg;
            `ADDR_OPTION: reg_rdata_o <= option_reg;
            `ADDR_PORT_A: reg_rdata_o <= {3'h0, pa_sync2_reg};
            `ADDR_PORT_A_DIR: reg_rdata_o <= {3'h0, pa_dir_reg};
            `ADDR_PORT_B: reg_rdata_o <= pb_sync2_reg;
            `ADDR_PORT_B_DIR: reg_rdata_o <= pb_dir_reg;
            `ADDR_NVM_DATA: reg_rdata_o <= nvm_data_reg;
            `ADDR_NVM_ADDR: reg_rdata_o <= nvm_addr_reg;
            default: reg_rdata_o <= `BYTE_ZERO;
        endcase
    end
end

// =============================================
// pin drivers
// bit 4 can only pull low, so a latched one leaves the pin to the counter input
assign port_a_out_o = pa_latch_reg & 5'h0f;
assign port_a_oe_o = ~pa_dir_reg &
    {~pa_latch_reg[`PA_OPEN_COLL], 4'hf};
assign port_b_out_o = pb_latch_reg;
assign port_b_oe_o = ~pb_dir_reg;
assign port_b_pullup_en_o = option_reg[`OPT_PULLUP_OFF] ?
    `ALL_OUT_LOW : pb_dir_reg;
assign port_change_flag_o = int_ctrl_reg[`INT_PB_CHANGE];
assign pc_o = pc_reg;
assign asleep_o = asleep_reg;
assign nvm_addr_o = nvm_addr_reg[5:0];
assign nvm_data_o = nvm_data_reg;

endmodule // core_special_registers

`default_nettype wire

// [core_special_registers_defs.vh]
// register offsets, field positions, reset values and fixed sizes of the core special registers
`ifndef CORE_SPECIAL_REGISTERS_DEFS_VH
`define CORE_SPECIAL_REGISTERS_DEFS_VH

// effective register addresses (bank bit in address bit 7)
`define ADDR_INDIRECT 8'h00
`define ADDR_PC_LOW 8'h02
`define ADDR_STATUS 8'h03
`define ADDR_POINTER 8'h04
`define ADDR_PORT_A 8'h05
`define ADDR_PORT_B 8'h06
`define ADDR_NVM_DATA 8'h08
`define ADDR_NVM_ADDR 8'h09
`define ADDR_PC_LATCH 8'h0a
`define ADDR_INT_CTRL 8'h0b
`define ADDR_OPTION 8'h81
`define ADDR_PORT_A_DIR 8'h85
`define ADDR_PORT_B_DIR 8'h86
`define ADDR_DIRECT_MASK 8'h7f

// status field positions
`define ST_CARRY 0
`define ST_NIBBLE 1
`define ST_ZERO 2
`define ST_SLEEP 3
`define ST_WDOG 4
`define ST_BANK_LO 5
`define ST_BANK_HI 6
`define ST_IND_BANK 7

// other field positions
`define OPT_PULLUP_OFF 7
`define INT_PB_CHANGE 0
`define PA_OPEN_COLL 4
`define ALU_MSB 7
`define ALU_LSB 0
`define NIBBLE_MSB 3

// sizes, reset values and constants
`define PC_W 13
`define PC_LO_W 8
`define PC_HI_W 5
`define STACK_PTR_W 3
`define PA_W 5
`define NVM_ADDR_W 6
`define RESET_VECTOR 13'h0000
`define INT_VECTOR 13'h0004
`define PC_ONE 13'h0001
`define SP_ONE 3'h1
`define OPTION_RESET 8'hff
`define DIR_A_RESET 5'h1f
`define DIR_B_RESET 8'hff
`define BYTE_ZERO 8'h00
`define ALL_OUT_LOW 8'h00
`define STATUS_RESET 8'h18
`define PB_FILL_MSB 2

`endif

// [pin_world.sv]
// far-side model of the port pins: external drivers, pull-ups and open collector
`timescale 1ns/1ps
`default_nettype none
module pin_world (
    // clock
    input wire logic ref_clk_i,
    // device side
    input wire logic [4:0] a_out_i,
    input wire logic [4:0] a_oe_i,
    input wire logic [7:0] b_out_i,
    input wire logic [7:0] b_oe_i,
    input wire logic [7:0] b_pu_i,
    // bench side
    input wire logic [4:0] a_ext_i,
    input wire logic [4:0] a_ext_en_i,
    input wire logic [7:0] b_ext_i,
    input wire logic [7:0] b_ext_en_i,
    // resolved pins
    output logic [4:0] a_pin_o,
    output logic [7:0] b_pin_o
);
    // =========================
    // pin resolution
    // a released line without a pull-up wanders, so a stale level never reads back as valid
    logic [7:0] drift = 8'h55;
    always @(posedge ref_clk_i) drift <= ~drift;
    // bit 4 only ever pulls low, its high level comes from outside
    assign a_pin_o = (a_oe_i & a_out_i) | (~a_oe_i & a_ext_en_i & a_ext_i)
        | (~a_oe_i & ~a_ext_en_i & drift[4:0]);
    assign b_pin_o = (b_oe_i & b_out_i) | (~b_oe_i & b_ext_en_i & b_ext_i)
        | (~b_oe_i & ~b_ext_en_i & (b_pu_i | drift));
endmodule // pin_world
`default_nettype wire

// [reg_watch_monitor.sv]
// concurrent checks on the core special registers
`timescale 1ns/1ps
`default_nettype none
`include "core_special_registers_defs.vh"
module reg_watch (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic reset_n_i,
    input wire logic clk_en_i,
    // sequencer
    input wire logic reg_wr_i,
    input wire logic pc_step_i,
    input wire logic jump_i,
    input wire logic call_i,
    input wire logic [7:0] target_i,
    input wire logic int_ack_i,
    input wire logic return_i,
    input wire logic halt_i,
    input wire logic wdt_timeout_i,
    input wire logic ext_reset_i,
    input wire logic [12:0] pc_o,
    input wire logic asleep_o,
    // pins
    input wire logic [4:0] port_a_out_o,
    input wire logic [7:0] port_b_oe_o,
    input wire logic [7:0] port_b_pullup_en_o,
    input wire logic port_change_flag_o
);
    // =========================
    // properties
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!reset_n_i);
    // resets outrank every other sequencer and status event, so the sequencer and change-flag checks judge only quiet cycles
    wire quiet = clk_en_i && !wdt_timeout_i && !ext_reset_i;
    wire no_load = !(int_ack_i || call_i || jump_i);
    sequence s_call;
        quiet && call_i && !int_ack_i;
    endsequence
    sequence s_ret;
        quiet && return_i && no_load;
    endsequence
    sequence s_gap;
        quiet && !int_ack_i && !call_i && !return_i;
    endsequence
    int_vector_a: assert property (quiet && int_ack_i |=> pc_o == `INT_VECTOR)
        else $error("interrupt did not load the vector");
    jump_low_a: assert property (quiet && jump_i && !int_ack_i && !call_i
        |=> pc_o[7:0] == $past(target_i)) else $error("jump target not loaded");
    call_return_a: assert property (s_call ##1 s_gap ##1 s_ret
        |=> pc_o == $past(pc_o, 3) + `PC_ONE)
        else $error("return did not restore the pushed address");
    pc_step_a: assert property (quiet && pc_step_i && !asleep_o && !halt_i && !reg_wr_i
        && no_load && !return_i |=> pc_o == $past(pc_o) + `PC_ONE)
        else $error("pc did not step by one");
    halt_sleep_a: assert property (quiet && halt_i |=> asleep_o)
        else $error("halt did not enter sleep");
    open_coll_a: assert property (port_a_out_o[4] == 1'b0)
        else $error("port a bit 4 drives high");
    pullup_out_a: assert property ((port_b_pullup_en_o & port_b_oe_o) == 8'h00)
        else $error("pull-up on an output pin");
    pullup_reset_a: assert property ($rose(reset_n_i) |-> port_b_pullup_en_o == 8'h00)
        else $error("pull-ups on after reset");
    flag_sticky_a: assert property (port_change_flag_o && quiet && !reg_wr_i
        |=> port_change_flag_o) else $error("change flag dropped by itself");
endmodule // reg_watch
bind core_special_registers reg_watch u_watch (.*);
`default_nettype wire

// [core_special_registers_test.sv]
// self-checking bench for the core special registers
`timescale 1ns/1ps
`default_nettype none
`include "core_special_registers_defs.vh"
module core_special_registers_test;
    // =========================
    // signals
    localparam logic [14:0] CALL = 15'h4000, JUMP = 15'h2000, INTA = 15'h1000, RET = 15'h0800;
    localparam logic [14:0] STEP = 15'h0400, HALT = 15'h0200, KICK = 15'h0100, WDT = 15'h0080;
    localparam logic [14:0] EXT = 15'h0040, ADD = 15'h0020, SUB = 15'h0030, LOGOP = 15'h0008;
    localparam logic [14:0] ROTL = 15'h0004, ROTR = 15'h0002, LOAD = 15'h0001;
    logic ref_clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic [6:0] reg_addr_i = 7'h00;
    logic [7:0] reg_wdata_i = 8'h00;
    logic [14:0] ctl = 15'h0000;
    logic [7:0] da = 8'h00;
    logic [7:0] db = 8'h00;
    logic [4:0] a_ext = 5'h0a;
    logic [4:0] a_en = 5'h1e;
    logic [7:0] b_ext = 8'hff;
    logic [7:0] b_en = 8'hff;
    logic [7:0] reg_rdata_o, nvm_data_o, port_b_out_o, port_b_oe_o, port_b_pullup_en_o;
    logic [7:0] port_b_pin_i, bb;
    logic [4:0] port_a_pin_i, port_a_out_o, port_a_oe_o, nib;
    logic [12:0] pc_o, epc;
    logic [12:0] stk [8];
    logic [5:0] nvm_addr_o;
    logic [8:0] sum;
    logic asleep_o, port_change_flag_o;
    logic [16:0] alu_tab [5] = '{17'h00f01, 17'h0ff01, 17'h10505, 17'h10305, 17'h13300};
    int mismatches = 0;
    int n_checks = 0;
    int cycles = 0;
    always #25 ref_clk_i = ~ref_clk_i;
    core_special_registers dut (
        .ref_clk_i, .reset_n_i, .clk_en_i(1'b1), .reg_addr_i, .reg_wdata_i, .reg_wr_i,
        .reg_rd_i, .reg_rdata_o, .pc_step_i(ctl[10]), .jump_i(ctl[13]), .call_i(ctl[14]),
        .target_i(da), .int_ack_i(ctl[12]), .return_i(ctl[11]), .halt_i(ctl[9]),
        .wdt_kick_i(ctl[8]), .wdt_timeout_i(ctl[7]), .ext_reset_i(ctl[6]), .pc_o, .asleep_o,
        .arith_valid_i(ctl[5]), .arith_sub_i(ctl[4]), .op_a_i(da), .op_b_i(db),
        .logic_valid_i(ctl[3]), .logic_result_i(da), .rotate_left_i(ctl[2]),
        .rotate_right_i(ctl[1]), .rotate_src_i(da), .nvm_load_i(ctl[0]), .nvm_rdata_i(da),
        .nvm_addr_o, .nvm_data_o, .port_a_pin_i, .port_a_out_o, .port_a_oe_o, .port_b_pin_i,
        .port_b_out_o, .port_b_oe_o, .port_b_pullup_en_o, .port_change_flag_o
    );
    pin_world ext (
        .ref_clk_i, .a_out_i(port_a_out_o), .a_oe_i(port_a_oe_o), .b_out_i(port_b_out_o),
        .b_oe_i(port_b_oe_o), .b_pu_i(port_b_pullup_en_o), .a_ext_i(a_ext), .a_ext_en_i(a_en),
        .b_ext_i(b_ext), .b_ext_en_i(b_en), .a_pin_o(port_a_pin_i), .b_pin_o(port_b_pin_i)
    );
    // =========================
    // tasks
    task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
        n_checks++;
        if (g !== e)
        begin
            mismatches++;
            $display("Error %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk_i);
        reg_wr_i <= 1'b1;
        reg_addr_i <= a[6:0];
        reg_wdata_i <= d;
        @(posedge ref_clk_i);
        reg_wr_i <= 1'b0;
        #1;
    endtask
    task automatic rchk(input string what, input logic [7:0] a, input logic [7:0] m,
        input logic [7:0] e);
        @(posedge ref_clk_i);
        reg_rd_i <= 1'b1;
        reg_addr_i <= a[6:0];
        @(posedge ref_clk_i);
        reg_rd_i <= 1'b0;
        #1;
        chk(what, 16'(e), 16'(reg_rdata_o & m));
    endtask
    task automatic fire(input logic [14:0] m, input logic [7:0] d0, input logic [7:0] d1);
        @(posedge ref_clk_i);
        ctl <= m;
        da <= d0;
        db <= d1;
        @(posedge ref_clk_i);
        ctl <= 15'h0000;
        #1;
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge ref_clk_i);
        #1;
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // the whole run needs well under a thousand cycles
    always @(posedge ref_clk_i)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            mismatches++;
            give_verdict();
        end
    end
    // =========================
    // tests
    initial
    begin
        repeat (5) @(posedge ref_clk_i);
        reset_n_i <= 1'b1;
        idle(1);
        chk("pc", 16'h0000, 16'(pc_o));
        rchk("status", `ADDR_STATUS, 8'hff, 8'h18);
        chk("flag after reset", 16'h0000, 16'(port_change_flag_o));
        $display("test reset done");
        wr(`ADDR_NVM_ADDR, 8'hff);
        chk("nvm addr", 16'h003f, 16'(nvm_addr_o));
        wr(`ADDR_PC_LATCH, 8'hff);
        rchk("latch", `ADDR_PC_LATCH, 8'hff, 8'h1f);
        fire(LOAD, 8'h96, 8'h00);
        chk("nvm data out", 16'h0096, 16'(nvm_data_o));
        rchk("nvm data", `ADDR_NVM_DATA, 8'hff, 8'h96);
        wr(`ADDR_POINTER, `ADDR_NVM_ADDR);
        rchk("pointer", `ADDR_POINTER, 8'hff, 8'h09);
        wr(`ADDR_INDIRECT, 8'h2a);
        chk("indirect write", 16'h002a, 16'(nvm_addr_o));
        rchk("indirect read", `ADDR_INDIRECT, 8'hff, 8'h2a);
        $display("test registers done");
        wr(`ADDR_PC_LATCH, 8'h15);
        fire(JUMP, 8'h34, 8'h00);
        chk("jump pc", 16'h1534, 16'(pc_o));
        wr(`ADDR_PC_LOW, 8'h77);
        chk("pc write", 16'h1577, 16'(pc_o));
        fire(STEP, 8'h00, 8'h00);
        rchk("pc low", `ADDR_PC_LOW, 8'hff, 8'h78);
        epc = 13'h1578;
        fire(INTA, 8'h00, 8'h00);
        chk("vector", 16'(`INT_VECTOR), 16'(pc_o));
        fire(RET, 8'h00, 8'h00);
        chk("int return", 16'(epc), 16'(pc_o));
        for (int i = 0; i < 8; i++)
        begin
            stk[i] = epc + `PC_ONE;
            epc = {5'h15, 4'(i), 4'h1};
            fire(CALL, epc[7:0], 8'h00);
            chk("call pc", 16'(epc), 16'(pc_o));
        end
        for (int i = 7; i >= 0; i--)
        begin
            fire(RET, 8'h00, 8'h00);
            chk("return pc", 16'(stk[i]), 16'(pc_o));
        end
        $display("test stack done");
        for (int i = 0; i < 5; i++)
        begin
            bb = alu_tab[i][16] ? ~alu_tab[i][7:0] : alu_tab[i][7:0];
            sum = {1'b0, alu_tab[i][15:8]} + {1'b0, bb} + 9'(alu_tab[i][16]);
            nib = {1'b0, alu_tab[i][11:8]} + {1'b0, bb[3:0]} + 5'(alu_tab[i][16]);
            fire(alu_tab[i][16] ? SUB : ADD, alu_tab[i][15:8], alu_tab[i][7:0]);
            rchk("alu", `ADDR_STATUS, 8'h07,
                {5'h00, sum[7:0] == 8'h00, nib[4], sum[8]});
        end
        fire(LOGOP, 8'h00, 8'h00);
        rchk("zero", `ADDR_STATUS, 8'h04, 8'h04);
        fire(LOGOP, 8'h40, 8'h00);
        rchk("nonzero", `ADDR_STATUS, 8'h04, 8'h00);
        fire(ROTL, 8'h80, 8'h00);
        rchk("rotate left", `ADDR_STATUS, 8'h01, 8'h01);
        fire(ROTR, 8'h80, 8'h00);
        rchk("rotate right", `ADDR_STATUS, 8'h01, 8'h00);
        $display("test flags done");
        wr(`ADDR_STATUS, 8'he0);
        rchk("status high", `ADDR_STATUS, 8'hf8, 8'hf8);
        wr(`ADDR_PORT_A_DIR, 8'h1e);
        chk("port a oe", 16'h0001, 16'(port_a_oe_o));
        wr(`ADDR_PORT_B_DIR, 8'h0f);
        chk("port b oe", 16'h00f0, 16'(port_b_oe_o));
        wr(`ADDR_OPTION, 8'hff);
        chk("pullups off", 16'h0000, 16'(port_b_pullup_en_o));
        wr(`ADDR_OPTION, 8'h7f);
        chk("pullups on", 16'h000f, 16'(port_b_pullup_en_o));
        wr(`ADDR_STATUS, 8'h00);
        b_en <= 8'hf0;
        wr(`ADDR_PORT_A, 8'h1f);
        chk("port a out", 16'h000f, 16'(port_a_out_o));
        wr(`ADDR_PORT_B, 8'ha5);
        idle(3);
        rchk("port a pins", `ADDR_PORT_A, 8'h1f, 8'h0b);
        rchk("port b pins", `ADDR_PORT_B, 8'hff, 8'haf);
        wr(`ADDR_INT_CTRL, 8'h00);
        wr(`ADDR_PORT_B, 8'h50);
        idle(6);
        chk("output change", 16'h0000, 16'(port_change_flag_o));
        wr(`ADDR_STATUS, 8'h20);
        wr(`ADDR_PORT_B_DIR, 8'hff);
        wr(`ADDR_STATUS, 8'h00);
        idle(6);
        wr(`ADDR_INT_CTRL, 8'h00);
        b_ext <= 8'hbf;
        idle(6);
        chk("input change", 16'h0001, 16'(port_change_flag_o));
        idle(8);
        chk("flag held", 16'h0001, 16'(port_change_flag_o));
        wr(`ADDR_INT_CTRL, 8'h00);
        chk("flag cleared", 16'h0000, 16'(port_change_flag_o));
        $display("test ports done");
        fire(HALT, 8'h00, 8'h00);
        chk("asleep", 16'h0001, 16'(asleep_o));
        rchk("halt flags", `ADDR_STATUS, 8'h18, 8'h10);
        b_ext <= 8'hff;
        idle(6);
        chk("woken", 16'h0000, 16'(asleep_o));
        fire(KICK, 8'h00, 8'h00);
        rchk("kick flags", `ADDR_STATUS, 8'h18, 8'h18);
        fire(WDT, 8'h00, 8'h00);
        chk("wdt pc", 16'h0000, 16'(pc_o));
        rchk("wdt awake", `ADDR_STATUS, 8'h18, 8'h08);
        fire(EXT, 8'h00, 8'h00);
        rchk("ext awake", `ADDR_STATUS, 8'h18, 8'h08);
        fire(HALT, 8'h00, 8'h00);
        fire(WDT, 8'h00, 8'h00);
        rchk("wdt asleep", `ADDR_STATUS, 8'h18, 8'h00);
        fire(KICK, 8'h00, 8'h00);
        fire(HALT, 8'h00, 8'h00);
        fire(EXT, 8'h00, 8'h00);
        rchk("ext asleep", `ADDR_STATUS, 8'h18, 8'h10);
        $display("test sleep done");
        give_verdict();
    end
endmodule // core_special_registers_test
`default_nettype wire
